// >>> inc/serial_ddc_map.vh
// Register map, field positions, reset values and codes of the serial and decimation config bank
`ifndef SERIAL_DDC_MAP_VH
`define SERIAL_DDC_MAP_VH

// ==================================================
// Page bases (register indices, byte address = 4 * index)
`define JESD_PAGE_BASE 16'h6000
`define DEC_PAGE_A_BASE 16'h5000
`define DEC_PAGE_B_BASE 16'h5800

// ==================================================
// Register offsets within their page (indices)
`define REG_DDC_ENABLE 16'h0000
`define REG_DECIM_RATIO 16'h0001
`define REG_COMPANION 16'h0016
`define REG_SYNC_SELECT 16'h0036
`define REG_PLL_MULT 16'h0037
`define REG_SYSREF_MASK 16'h003e

// ==================================================
// Internal register select codes
`define SEL_NONE 4'h0
`define SEL_SYNC 4'h1
`define SEL_PLL 4'h2
`define SEL_SYSREF 4'h3
`define SEL_COMPANION 4'h4
`define SEL_A_ENABLE 4'h5
`define SEL_A_RATIO 4'h6
`define SEL_B_ENABLE 4'h7
`define SEL_B_RATIO 4'h8

// ==================================================
// Field positions and widths
`define SYNC_SEL_BIT 6
`define PLL_LSB 0
`define PLL_MSB 1
`define CLKDIV_MASK_BIT 6
`define OSC_MASK_BIT 5
`define COMP_LSB 4
`define COMP_MSB 6
`define DOWNCONVERTER_ENABLE_BIT 0
`define RATIO_LSB 0
`define RATIO_MSB 3

// ==================================================
// Reset values
`define RESET_BYTE 8'h00
`define RESET_RATIO_CODE 4'h0
`define RESET_PLL_CODE 2'h0

// ==================================================
// Multiplier codes and factors
`define PLL_CODE_20X 2'h0
`define PLL_CODE_16X 2'h1
`define PLL_CODE_40X 2'h2
`define PLL_CODE_80X 2'h3
`define FACTOR_20X 7'h14
`define FACTOR_16X 7'h10
`define FACTOR_40X 7'h28
`define FACTOR_80X 7'h50
`define COMP_40X 3'h7
`define COMP_OTHER 3'h0

// ==================================================
// Decimation ratio codes and values
`define DEC_CODE_4 4'h0
`define DEC_CODE_6 4'h1
`define DEC_CODE_8 4'h2
`define DEC_CODE_9 4'h3
`define DEC_CODE_10 4'h4
`define DEC_CODE_12 4'h5
`define DEC_CODE_16 4'h7
`define DEC_CODE_18 4'h8
`define DEC_CODE_20 4'h9
`define DEC_CODE_24 4'ha
`define DEC_CODE_32 4'hc
`define DEC_4 6'h04
`define DEC_6 6'h06
`define DEC_8 6'h08
`define DEC_9 6'h09
`define DEC_10 6'h0a
`define DEC_12 6'h0c
`define DEC_16 6'h10
`define DEC_18 6'h12
`define DEC_20 6'h14
`define DEC_24 6'h18
`define DEC_32 6'h20
`define DEC_NONE 6'h00

`endif

// >>> hdl/ddc_channel_cfg.v
// Per-channel decimation page: down-converter enable and decimation ratio select
module ddc_channel_cfg (
   // Clock and reset
   input wire mclk,
   input wire rst_b,
   // Register access from the bus slave
   input wire wr_enable,
   input wire wr_ratio,
   input wire [7:0] wr_data,
   input wire rd_ratio,
   output wire [7:0] rd_data,
   // Channel controls
   output reg downconverter_enable,
   output reg decimation_bypass,
   output reg [3:0] decimation_ratio_select,
   output reg [5:0] decimation_ratio,
   output reg ratio_valid
);
`include "serial_ddc_map.vh"

   // ==================================================
   // Ratio decode
   function [5:0] ratio_of;
      input [3:0] code;
      begin
         case (code)
            `DEC_CODE_4: ratio_of = `DEC_4;
            `DEC_CODE_6: ratio_of = `DEC_6;
            `DEC_CODE_8: ratio_of = `DEC_8;
            `DEC_CODE_9: ratio_of = `DEC_9;
            `DEC_CODE_10: ratio_of = `DEC_10;
            `DEC_CODE_12: ratio_of = `DEC_12;
            `DEC_CODE_16: ratio_of = `DEC_16;
            `DEC_CODE_18: ratio_of = `DEC_18;
            `DEC_CODE_20: ratio_of = `DEC_20;
            `DEC_CODE_24: ratio_of = `DEC_24;
            `DEC_CODE_32: ratio_of = `DEC_32;
            default: ratio_of = `DEC_NONE;
         endcase
      end
   endfunction

   wire [3:0] next_code;
   assign next_code = wr_data[`RATIO_MSB:`RATIO_LSB];

   // ==================================================
   // Storage; reserved bits are not kept and read back as zero
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         downconverter_enable <= 1'b0;
         decimation_bypass <= 1'b1;
         decimation_ratio_select <= `RESET_RATIO_CODE;
         decimation_ratio <= `DEC_4;
         ratio_valid <= 1'b1;
      end else begin
         if (wr_enable) begin
            downconverter_enable <= wr_data[`DOWNCONVERTER_ENABLE_BIT];
            decimation_bypass <= ~wr_data[`DOWNCONVERTER_ENABLE_BIT];
         end
         if (wr_ratio) begin
            decimation_ratio_select <= next_code;
            decimation_ratio <= ratio_of(next_code);
            ratio_valid <= (ratio_of(next_code) != `DEC_NONE);
         end
      end
   end

   assign rd_data = rd_ratio ? {4'h0, decimation_ratio_select} :
                    {7'h00, downconverter_enable};
endmodule

// >>> hdl/serial_ddc_cfg_regs.v
// APB register bank for serial-link sync, PLL multiplier, SYSREF masking and decimation pages
//
// The APB register port was left to the implementer.
module serial_ddc_cfg_regs (
   // Clock and reset
   input wire mclk,
   input wire rst_b,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // Sync request inputs and result
   input wire sync_diff_b,
   input wire aux_pin_four,
   output reg sync_request_b,
   // Serializer PLL
   output reg [1:0] pll_multiplier_code,
   output reg [6:0] pll_multiplier_factor,
   output reg [2:0] quad_rate_companion_setting,
   output reg pll_setting_consistent,
   // SYSREF distribution
   input wire sysref,
   output reg clock_divider_reset,
   output reg oscillator_phase_reset,
   output reg lmfc_counter_reset,
   // First channel decimation
   output wire ch_a_downconverter_enable,
   output wire ch_a_bypass,
   output wire [3:0] ch_a_ratio_select,
   output wire [5:0] ch_a_decimation_ratio,
   output wire ch_a_ratio_valid,
   // Second channel decimation
   output wire ch_b_downconverter_enable,
   output wire ch_b_bypass,
   output wire [3:0] ch_b_ratio_select,
   output wire [5:0] ch_b_decimation_ratio,
   output wire ch_b_ratio_valid
);
`include "serial_ddc_map.vh"

   // ==================================================
   // Address decode
   // Registers are one aligned word each; the printed offsets are word indices.
   function [3:0] decode;
      input [17:0] addr;
      reg [15:0] idx;
      begin
         idx = addr[17:2];
         decode = `SEL_NONE;
         if (addr[1:0] != 2'h0) begin
            decode = `SEL_NONE;
         end else begin
            case (idx)
               `JESD_PAGE_BASE + `REG_SYNC_SELECT: decode = `SEL_SYNC;
               `JESD_PAGE_BASE + `REG_PLL_MULT: decode = `SEL_PLL;
               `JESD_PAGE_BASE + `REG_SYSREF_MASK: decode = `SEL_SYSREF;
               `JESD_PAGE_BASE + `REG_COMPANION: decode = `SEL_COMPANION;
               `DEC_PAGE_A_BASE + `REG_DDC_ENABLE: decode = `SEL_A_ENABLE;
               `DEC_PAGE_A_BASE + `REG_DECIM_RATIO: decode = `SEL_A_RATIO;
               `DEC_PAGE_B_BASE + `REG_DDC_ENABLE: decode = `SEL_B_ENABLE;
               `DEC_PAGE_B_BASE + `REG_DECIM_RATIO: decode = `SEL_B_RATIO;
               default: decode = `SEL_NONE;
            endcase
         end
      end
   endfunction

   // ==================================================
   // PLL code to factor
   function [6:0] factor_of;
      input [1:0] code;
      begin
         case (code)
            `PLL_CODE_20X: factor_of = `FACTOR_20X;
            `PLL_CODE_16X: factor_of = `FACTOR_16X;
            `PLL_CODE_40X: factor_of = `FACTOR_40X;
            `PLL_CODE_80X: factor_of = `FACTOR_80X;
            default: factor_of = `FACTOR_20X;
         endcase
      end
   endfunction

   // ==================================================
   // Bus handshake
   // Zero wait states: read data is captured in the setup cycle so it can come
   // from a flop and still be valid throughout the access phase.
   wire [3:0] sel;
   wire setup_phase;
   wire access_phase;
   wire bad_addr;
   wire write_now;
   wire [7:0] wbyte;
   assign sel = decode(paddr);
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign pready = 1'b1;
   // Misaligned and unmapped addresses answer with an error and change nothing
   assign bad_addr = (sel == `SEL_NONE);
   // Only byte lane 0 carries data; a write without that strobe changes nothing
   assign write_now = access_phase & pwrite & pready & pstrb[0] & ~bad_addr;
   assign wbyte = pwdata[7:0];

   // ==================================================
   // Decimation page strobes
   // Named once here so both channel instances stay plain port-to-wire hookups
   wire wr_a_enable;
   wire wr_a_ratio;
   wire wr_b_enable;
   wire wr_b_ratio;
   wire rd_a_ratio;
   wire rd_b_ratio;
   assign wr_a_enable = write_now & (sel == `SEL_A_ENABLE);
   assign wr_a_ratio = write_now & (sel == `SEL_A_RATIO);
   assign wr_b_enable = write_now & (sel == `SEL_B_ENABLE);
   assign wr_b_ratio = write_now & (sel == `SEL_B_RATIO);
   assign rd_a_ratio = (sel == `SEL_A_RATIO);
   assign rd_b_ratio = (sel == `SEL_B_RATIO);

   // ==================================================
   // JESD page storage
   reg single_ended_sync_select;
   reg clock_divider_sysref_mask;
   reg oscillator_lmfc_sysref_mask;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         single_ended_sync_select <= 1'b0;
         pll_multiplier_code <= `RESET_PLL_CODE;
         pll_multiplier_factor <= `FACTOR_20X;
         clock_divider_sysref_mask <= 1'b0;
         oscillator_lmfc_sysref_mask <= 1'b0;
         quad_rate_companion_setting <= `COMP_OTHER;
      end else if (write_now) begin
         // Reserved bits are simply not stored, so whatever lands there is harmless
         case (sel)
            `SEL_SYNC: begin
               single_ended_sync_select <= wbyte[`SYNC_SEL_BIT];
            end
            `SEL_PLL: begin
               pll_multiplier_code <= wbyte[`PLL_MSB:`PLL_LSB];
               pll_multiplier_factor <= factor_of(wbyte[`PLL_MSB:`PLL_LSB]);
            end
            `SEL_SYSREF: begin
               clock_divider_sysref_mask <= wbyte[`CLKDIV_MASK_BIT];
               oscillator_lmfc_sysref_mask <= wbyte[`OSC_MASK_BIT];
            end
            `SEL_COMPANION: begin
               quad_rate_companion_setting <= wbyte[`COMP_MSB:`COMP_LSB];
            end
            default: begin
               single_ended_sync_select <= single_ended_sync_select;
            end
         endcase
      end
   end

   // ==================================================
   // Companion consistency, one cycle behind the fields
   // The device cannot enforce the pairing; it only reports it for software.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pll_setting_consistent <= 1'b1;
      end else if (pll_multiplier_code == `PLL_CODE_40X) begin
         pll_setting_consistent <= (quad_rate_companion_setting == `COMP_40X);
      end else if (pll_multiplier_code == `PLL_CODE_16X) begin
         pll_setting_consistent <= 1'b1;
      end else begin
         pll_setting_consistent <= (quad_rate_companion_setting == `COMP_OTHER);
      end
   end

   // ==================================================
   // Sync request source
   // One flop of delay; both pins are taken as already synchronous to mclk
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync_request_b <= 1'b1;
      end else if (single_ended_sync_select) begin
         sync_request_b <= aux_pin_four;
      end else begin
         sync_request_b <= sync_diff_b;
      end
   end

   // ==================================================
   // SYSREF edge detection and masking
   // A level held high gives one pulse only; masking mid-pulse drops it cleanly.
   reg sysref_prev;
   wire sysref_rise;
   assign sysref_rise = sysref & ~sysref_prev;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sysref_prev <= 1'b0;
         clock_divider_reset <= 1'b0;
         oscillator_phase_reset <= 1'b0;
         lmfc_counter_reset <= 1'b0;
      end else begin
         sysref_prev <= sysref;
         clock_divider_reset <= sysref_rise & ~clock_divider_sysref_mask;
         oscillator_phase_reset <= sysref_rise & ~oscillator_lmfc_sysref_mask;
         lmfc_counter_reset <= sysref_rise & ~oscillator_lmfc_sysref_mask;
      end
   end

   // ==================================================
   // Decimation pages, one per channel
   // Both pages share the write byte; only the addressed one sees its strobe
   wire [7:0] ch_a_rd;
   wire [7:0] ch_b_rd;

   ddc_channel_cfg u_ch_a (
      .mclk(mclk),
      .rst_b(rst_b),
      .wr_enable(wr_a_enable),
      .wr_ratio(wr_a_ratio),
      .wr_data(wbyte),
      .rd_ratio(rd_a_ratio),
      .rd_data(ch_a_rd),
      .downconverter_enable(ch_a_downconverter_enable),
      .decimation_bypass(ch_a_bypass),
      .decimation_ratio_select(ch_a_ratio_select),
      .decimation_ratio(ch_a_decimation_ratio),
      .ratio_valid(ch_a_ratio_valid)
   );

   ddc_channel_cfg u_ch_b (
      .mclk(mclk),
      .rst_b(rst_b),
      .wr_enable(wr_b_enable),
      .wr_ratio(wr_b_ratio),
      .wr_data(wbyte),
      .rd_ratio(rd_b_ratio),
      .rd_data(ch_b_rd),
      .downconverter_enable(ch_b_downconverter_enable),
      .decimation_bypass(ch_b_bypass),
      .decimation_ratio_select(ch_b_ratio_select),
      .decimation_ratio(ch_b_decimation_ratio),
      .ratio_valid(ch_b_ratio_valid)
   );

   // ==================================================
   // Read mux; write-only reserved bits read as zero
   reg [7:0] rd_byte;
   always @* begin
      rd_byte = `RESET_BYTE;
      case (sel)
         // Fields sit at the same named positions the write path uses; the rest stay zero
         `SEL_SYNC: begin
            rd_byte[`SYNC_SEL_BIT] = single_ended_sync_select;
         end
         `SEL_PLL: begin
            rd_byte[`PLL_MSB:`PLL_LSB] = pll_multiplier_code;
         end
         `SEL_SYSREF: begin
            rd_byte[`CLKDIV_MASK_BIT] = clock_divider_sysref_mask;
            rd_byte[`OSC_MASK_BIT] = oscillator_lmfc_sysref_mask;
         end
         `SEL_COMPANION: begin
            rd_byte[`COMP_MSB:`COMP_LSB] = quad_rate_companion_setting;
         end
         `SEL_A_ENABLE: rd_byte = ch_a_rd;
         `SEL_A_RATIO: rd_byte = ch_a_rd;
         `SEL_B_ENABLE: rd_byte = ch_b_rd;
         `SEL_B_RATIO: rd_byte = ch_b_rd;
         default: rd_byte = `RESET_BYTE;
      endcase
   end

   // ==================================================
   // Registered read data and error, loaded in the setup cycle
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= {24'h000000, rd_byte};
         pslverr <= bad_addr;
      // Drop the data when idle so a stale read never lingers on the bus
      end else if (!psel) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end
endmodule

// >>> bench/serial_ddc_cfg_sva.sv
// Concurrent checks on the ports of the serial and decimation config bank
module serial_ddc_cfg_sva (
   // Clock, reset and bus
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   // Sync, PLL and SYSREF
   input wire logic sync_diff_b,
   input wire logic aux_pin_four,
   input wire logic sync_request_b,
   input wire logic [1:0] pll_multiplier_code,
   input wire logic [6:0] pll_multiplier_factor,
   input wire logic sysref,
   input wire logic clock_divider_reset,
   input wire logic oscillator_phase_reset,
   input wire logic lmfc_counter_reset,
   // First channel
   input wire logic ch_a_downconverter_enable,
   input wire logic ch_a_bypass
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==================================================
   // Shadow of the select and mask bits, taken from bus writes
   logic sync_sel, mask_clk, mask_osc, sysref_q;
   wire wr_go = psel && penable && pwrite && pstrb[0];
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync_sel <= 1'b0;
         mask_clk <= 1'b0;
         mask_osc <= 1'b0;
         sysref_q <= 1'b0;
      end else begin
         sysref_q <= sysref;
         if (wr_go && paddr == 18'h180d8) sync_sel <= pwdata[6];
         if (wr_go && paddr == 18'h180f8) mask_clk <= pwdata[6];
         if (wr_go && paddr == 18'h180f8) mask_osc <= pwdata[5];
      end
   end
   function automatic logic mapped(input logic [17:0] a);
      return a inside {18'h180d8, 18'h180dc, 18'h180f8, 18'h18058,
                       18'h14000, 18'h14004, 18'h16000, 18'h16004};
   endfunction
   // ==================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_sync_source_pick: assert property ($past(rst_b) |-> sync_request_b ==
      $past(sync_sel ? aux_pin_four : sync_diff_b)) else $error("sync source wrong");
   a_pll_factor_map: assert property (pll_multiplier_factor == (pll_multiplier_code == 2'h0 ?
      7'h14 : pll_multiplier_code == 2'h1 ? 7'h10 : pll_multiplier_code == 2'h2 ? 7'h28 : 7'h50))
      else $error("pll factor wrong");
   a_clkdiv_pulse: assert property ($past(rst_b) |-> clock_divider_reset ==
      $past(sysref && !sysref_q && !mask_clk)) else $error("clock divider pulse wrong");
   a_osc_pulse: assert property ($past(rst_b) |-> oscillator_phase_reset ==
      $past(sysref && !sysref_q && !mask_osc)) else $error("oscillator pulse wrong");
   a_lmfc_with_osc: assert property (lmfc_counter_reset == oscillator_phase_reset)
      else $error("lmfc pulse apart from oscillator pulse");
   a_bypass_inverse: assert property (ch_a_bypass != ch_a_downconverter_enable)
      else $error("bypass not inverse of enable");
   a_enable_write: assert property (wr_go && paddr == 18'h14000 |=>
      ch_a_downconverter_enable == $past(pwdata[0])) else $error("enable not written");
   a_ready_no_wait: assert property (psel && penable |-> pready)
      else $error("bus not ready");
   a_unmapped_error: assert property (psel && penable |-> pslverr == !mapped(paddr))
      else $error("error response wrong");
   a_reset_clear: assert property ($rose(rst_b) |-> pll_multiplier_code == 2'h0 &&
      !ch_a_downconverter_enable && sync_request_b) else $error("reset values wrong");
   c_sysref_hit: cover property (clock_divider_reset);
   c_quad_rate: cover property (pll_multiplier_code == 2'h2);
   c_ch_a_on: cover property (ch_a_downconverter_enable);
endmodule

bind serial_ddc_cfg_regs serial_ddc_cfg_sva chk_u (.mclk(mclk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .pslverr(pslverr), .sync_diff_b(sync_diff_b), .aux_pin_four(aux_pin_four),
   .sync_request_b(sync_request_b), .pll_multiplier_code(pll_multiplier_code),
   .pll_multiplier_factor(pll_multiplier_factor), .sysref(sysref),
   .clock_divider_reset(clock_divider_reset), .oscillator_phase_reset(oscillator_phase_reset),
   .lmfc_counter_reset(lmfc_counter_reset),
   .ch_a_downconverter_enable(ch_a_downconverter_enable), .ch_a_bypass(ch_a_bypass));

// >>> bench/serial_ddc_cfg_regs_tb.sv
// Self-checking bench for the serial and decimation config bank
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
   $display("unexpected %s expected %h seen %h", what, exp, got); end end
module serial_ddc_cfg_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst_b, psel, penable, pwrite, sync_diff_b, aux_pin_four, sysref;
   logic [17:0] paddr;
   logic [31:0] pwdata, seed, v;
   logic [3:0] pstrb;
   logic [32:0] e;
   logic [32:0] notes[$];
   wire pready, pslverr, sync_request_b, consistent, div_rst, osc_rst, lmfc_rst;
   wire [31:0] prdata;
   wire [1:0] code;
   wire [6:0] factor;
   wire [2:0] comp;
   wire a_en, a_byp, a_ok, b_en, b_byp, b_ok;
   wire [3:0] a_sel, b_sel;
   wire [5:0] a_rat, b_rat;
   int errors, n_compared;
   // Order: sync, pll, sysref mask, companion, A enable, A ratio, B enable, B ratio
   logic [17:0] regs[8] = '{18'h180d8, 18'h180dc, 18'h180f8, 18'h18058,
                            18'h14000, 18'h14004, 18'h16000, 18'h16004};
   logic [7:0] mask[8] = '{8'h40, 8'h03, 8'h60, 8'h70, 8'h01, 8'h0f, 8'h01, 8'h0f};
   int dec[16] = '{4, 6, 8, 9, 10, 12, 0, 16, 18, 20, 24, 0, 32, 0, 0, 0};
   logic [6:0] fac[4] = '{7'h14, 7'h10, 7'h28, 7'h50};
   serial_ddc_cfg_regs dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .sync_diff_b(sync_diff_b),
      .aux_pin_four(aux_pin_four), .sync_request_b(sync_request_b),
      .pll_multiplier_code(code), .pll_multiplier_factor(factor),
      .quad_rate_companion_setting(comp), .pll_setting_consistent(consistent),
      .sysref(sysref), .clock_divider_reset(div_rst), .oscillator_phase_reset(osc_rst),
      .lmfc_counter_reset(lmfc_rst), .ch_a_downconverter_enable(a_en), .ch_a_bypass(a_byp),
      .ch_a_ratio_select(a_sel), .ch_a_decimation_ratio(a_rat), .ch_a_ratio_valid(a_ok),
      .ch_b_downconverter_enable(b_en), .ch_b_bypass(b_byp), .ch_b_ratio_select(b_sel),
      .ch_b_decimation_ratio(b_rat), .ch_b_ratio_valid(b_ok));
   // ==================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= 4'h1;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [17:0] a, input logic [32:0] x);
      notes.push_back(x);
      apb(1'b0, a, 8'h00);
   endtask
   // Let n edges pass, then look at settled outputs
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==================================================
   // Read monitor: every completed read is matched with the oldest note
   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite) begin
         e = notes.pop_front();
         `CHK("read word", e, {pslverr, prdata})
      end
   end
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      close_out();
   end
   // ==================================================
   // Scenarios
   initial begin
      seed = 32'h4667;
      {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb, sysref} = '0;
      {sync_diff_b, aux_pin_four} = 2'b11;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      settle(0);
      `CHK("factor", 7'h14, factor)
      `CHK("bypass", 1'b1, a_byp)
      foreach (regs[i]) rd(regs[i], 33'h0);
      $display("test reset done");
      foreach (regs[i]) begin
         v = rnd() & {24'h0, mask[i]};
         apb(1'b1, regs[i], v[7:0]);
         rd(regs[i], {1'b0, v});
      end
      $display("test readback done");
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, regs[3], c == 2 ? 8'h70 : 8'h00);
         apb(1'b1, regs[1], 8'(c));
         settle(0);
         `CHK("factor", fac[c], factor)
         `CHK("code", 2'(c), code)
         `CHK("companion", c == 2 ? 3'h7 : 3'h0, comp)
         settle(1);
         `CHK("consistent", 1'b1, consistent)
      end
      apb(1'b1, regs[1], 8'h02);
      apb(1'b1, regs[3], 8'h00);
      settle(1);
      `CHK("consistent", 1'b0, consistent)
      $display("test multiplier done");
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, regs[5], 8'(c));
         apb(1'b1, regs[7], 8'(15 - c));
         settle(0);
         `CHK("ratio a", 6'(dec[c]), a_rat)
         `CHK("valid a", dec[c] != 0, a_ok)
         `CHK("ratio b", 6'(dec[15 - c]), b_rat)
         `CHK("select a", 4'(c), a_sel)
         `CHK("select b", 4'(15 - c), b_sel)
         `CHK("valid b", dec[15 - c] != 0, b_ok)
      end
      apb(1'b1, regs[4], 8'h00);
      apb(1'b1, regs[6], 8'h01);
      settle(0);
      `CHK("bypass pair", 2'b10, {a_byp, b_byp})
      `CHK("enable pair", 2'b01, {a_en, b_en})
      $display("test decimation done");
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, regs[0], 8'(s << 6));
         repeat (4) begin
            v = rnd();
            @(posedge mclk);
            sync_diff_b <= v[0];
            aux_pin_four <= v[1];
            settle(1);
            `CHK("sync", s ? v[1] : v[0], sync_request_b)
         end
      end
      $display("test sync done");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, regs[2], 8'(m << 5));
         @(posedge mclk);
         sysref <= 1'b1;
         settle(1);
         `CHK("pulses", {!m[1], !m[0], !m[0]}, {div_rst, osc_rst, lmfc_rst})
         settle(1);
         `CHK("pulses", 3'h0, {div_rst, osc_rst, lmfc_rst})
         @(posedge mclk);
         sysref <= 1'b0;
      end
      $display("test sysref done");
      rd(18'h18000, 33'h1_0000_0000);
      rd(18'h180d9, 33'h1_0000_0000);
      apb(1'b1, 18'h16001, 8'h00);
      rd(regs[6], 33'h1);
      $display("test unmapped done");
      @(posedge mclk);
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      rd(regs[1], 33'h0);
      settle(0);
      `CHK("bypass", 1'b1, b_byp)
      $display("test second reset done");
      settle(3);
      close_out();
   end
endmodule
